// File: hw/dcw_pkg.sv
/*
 * package for the drive control word decoder: bit positions of the
 * motion control word and drive status word, state encodings.
 * assumes nothing of its surroundings.
 */
package dcw_pkg;
   // -------------------------------------------------------------
   // control word bit positions
   // -------------------------------------------------------------
   localparam int CW_WIDTH      = 16;
   localparam int CW_POWER_ON   = 0;
   localparam int CW_NO_COAST   = 1;
   localparam int CW_NO_QSTOP   = 2;
   localparam int CW_ENABLE_OP  = 3;
   localparam int CW_POS_PERMIT = 4;
   localparam int CW_NO_PAUSE   = 5;
   localparam int CW_TOGGLE     = 6;
   localparam int CW_FAULT_ACK  = 7;
   localparam int CW_JOG_POS    = 8;
   localparam int CW_JOG_NEG    = 9;
   localparam int CW_GUIDANCE   = 10;
   localparam int CW_HOME       = 11;
   localparam int CW_CONTINUOUS = 14;
   localparam logic [15:0] CW_RESET = 16'h0000;
   // bits 12, 13 and 15 are never decoded
   localparam logic [15:0] CW_USED_MASK = 16'h4FFF;

   // -------------------------------------------------------------
   // status word bit positions
   // -------------------------------------------------------------
   localparam int SW_READY_ON   = 0;
   localparam int SW_READY_OP   = 1;
   localparam int SW_OP_ENABLED = 2;
   localparam int SW_FAULT      = 3;
   localparam int SW_NO_COAST   = 4;
   localparam int SW_NO_QSTOP   = 5;
   localparam int SW_ON_DISABLE = 6;
   localparam int SW_GUIDANCE   = 9;
   localparam int SW_TARGET     = 10;
   localparam int SW_REF_VALID  = 11;
   localparam int SW_SET_ACK    = 12;
   localparam int SW_STOPPED    = 13;

   // -------------------------------------------------------------
   // power state machine, gray along on-disabled..enabled path
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      PS_ON_DISABLED = 3'h0,
      PS_READY_ON    = 3'h1,
      PS_READY_OP    = 3'h3,
      PS_OP_ENABLED  = 3'h2,
      PS_RAMP_OFF    = 3'h6,
      PS_QUICK_STOP  = 3'h7,
      PS_FAULT       = 3'h5
   } dcw_pstate_t;

   // ramp selector handed to the profile generator
   typedef enum logic [2:0] {
      RAMP_NONE  = 3'h0,
      RAMP_FIRST = 3'h1,
      RAMP_QUICK = 3'h2,
      RAMP_STOP  = 3'h3,
      RAMP_MAX   = 3'h4,
      RAMP_JOG   = 3'h5
   } dcw_ramp_t;
endpackage

// File: hw/dcw_decoder.sv
/*
 * drive control word decoder: takes the 16-bit motion control word
 * written cyclically by the fieldbus master, runs the power state
 * machine and issues motion commands to the profile generator.
 * assumes a single clock, status inputs synchronous to core_clk, and
 * a profile generator that reports standstill and homing completion.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - bit 0 set: ready for operation, energised
// - bit 0 clear: first ramp, de-energise, ready
// - bit 1 clear: power off, coast, disabled
// - bit 2 clear: quick ramp then de-energise
// - bit 3 set: enable operation, follow setpoint
// - bit 3 clear: stop ramp, ready for operation
// - bit 4 clear: max brake, discard order
// - bit 5 clear: pause, keep order, resume
// - bit 6 edges start orders when bit 4
// - bit 7 rising edge clears removed fault
// - bits 8/9 jog when enabled and idle
// - jog release brakes, stays operation enabled
// - bit 10 clear: only bit 10 observed
// - bit 10 clear: local inputs not combined
// - bit 11 rise starts homing, clears reference
// - bit 11 clear aborts homing with ramp
// - bit 14: reset positions on each order
// - quick stop releases operation disable
// - acknowledge bit 12 follows accepted toggle
module dcw_decoder #(
   parameter int CW_BITS = 16
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic [15:0] motionControlWord,
   input  wire logic [15:0] localInputWord,
   input  wire logic        faultActive,
   input  wire logic        faultRemoved,
   input  wire logic        axisStopped,
   input  wire logic        homingDone,
   input  wire logic        targetReached,
   input  wire logic        velocityOrGearing,
   output logic      [15:0] driveStatusWord,
   output logic             powerStageOn,
   output logic      [2:0]  rampSelect,
   output logic             motionRun,
   output logic             orderStart,
   output logic             orderDiscard,
   output logic             positionReset,
   output logic             jogPos,
   output logic             jogNeg,
   output logic             homingRun
);
   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   if (CW_BITS != dcw_pkg::CW_WIDTH) begin : g_chk
      $error("control word width must be sixteen");
   end

   // -------------------------------------------------------------
   // control word capture
   // -------------------------------------------------------------
   logic [15:0] cw_r, cw_nxt;
   logic [15:0] cwPrev_r, cwPrev_nxt;
   logic [15:0] effWord;

   // without guidance the stored word freezes except bit 10, and the
   // local inputs are never merged into it
   always_comb begin
      effWord = motionControlWord & dcw_pkg::CW_USED_MASK;
      cw_nxt  = cw_r;
      if (effWord[dcw_pkg::CW_GUIDANCE]) begin
         cw_nxt = effWord;
      end else begin
         cw_nxt[dcw_pkg::CW_GUIDANCE] = 1'b0;
      end
      cwPrev_nxt = cw_r;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cw_r     <= dcw_pkg::CW_RESET;
         cwPrev_r <= dcw_pkg::CW_RESET;
      end else if (clkEn) begin
         cw_r     <= cw_nxt;
         cwPrev_r <= cwPrev_nxt;
      end
   end

   // bit decode helpers
   function automatic logic rose(input logic [15:0] cur,
                                 input logic [15:0] prv,
                                 input int          b);
      rose = cur[b] & ~prv[b];
   endfunction

   logic onCmd, noCoast, noQstop, enOp, permit, noPause;
   logic toggleEdge, ackRise, homeRise;
   assign onCmd      = cw_r[dcw_pkg::CW_POWER_ON];
   assign noCoast    = cw_r[dcw_pkg::CW_NO_COAST];
   assign noQstop    = cw_r[dcw_pkg::CW_NO_QSTOP];
   assign enOp       = cw_r[dcw_pkg::CW_ENABLE_OP];
   assign permit     = cw_r[dcw_pkg::CW_POS_PERMIT];
   assign noPause    = cw_r[dcw_pkg::CW_NO_PAUSE];
   assign toggleEdge = cw_r[dcw_pkg::CW_TOGGLE]
                       ^ cwPrev_r[dcw_pkg::CW_TOGGLE];
   assign ackRise    = rose(cw_r, cwPrev_r, dcw_pkg::CW_FAULT_ACK);
   assign homeRise   = rose(cw_r, cwPrev_r, dcw_pkg::CW_HOME);

   // -------------------------------------------------------------
   // power state machine
   // -------------------------------------------------------------
   dcw_pkg::dcw_pstate_t ps_r, ps_nxt;

   // coast-off beats every control word request; fault beats all, coast-off included, but reset
   always_comb begin
      ps_nxt = ps_r;
      unique case (ps_r)
         dcw_pkg::PS_ON_DISABLED: begin
            // leave switch-on-disabled only with bit 0 low
            if (noCoast && noQstop && !onCmd) begin
               ps_nxt = dcw_pkg::PS_READY_ON;
            end
         end
         dcw_pkg::PS_READY_ON: begin
            if (!noCoast || !noQstop) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end else if (onCmd) begin
               ps_nxt = dcw_pkg::PS_READY_OP;
            end
         end
         dcw_pkg::PS_READY_OP: begin
            if (!noCoast) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end else if (!noQstop) begin
               ps_nxt = dcw_pkg::PS_QUICK_STOP;
            end else if (!onCmd) begin
               ps_nxt = dcw_pkg::PS_RAMP_OFF;
            end else if (enOp) begin
               ps_nxt = dcw_pkg::PS_OP_ENABLED;
            end
         end
         dcw_pkg::PS_OP_ENABLED: begin
            if (!noCoast) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end else if (!noQstop) begin
               ps_nxt = dcw_pkg::PS_QUICK_STOP;
            end else if (!onCmd) begin
               ps_nxt = dcw_pkg::PS_RAMP_OFF;
            end else if (!enOp && axisStopped) begin
               ps_nxt = dcw_pkg::PS_READY_OP;
            end
         end
         dcw_pkg::PS_RAMP_OFF: begin
            if (!noCoast) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end else if (!noQstop) begin
               ps_nxt = dcw_pkg::PS_QUICK_STOP;
            end else if (axisStopped) begin
               ps_nxt = dcw_pkg::PS_READY_ON;
            end
         end
         dcw_pkg::PS_QUICK_STOP: begin
            if (!noCoast || axisStopped) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end
         end
         dcw_pkg::PS_FAULT: begin
            if (ackRise && faultRemoved) begin
               ps_nxt = dcw_pkg::PS_ON_DISABLED;
            end
         end
         default: ps_nxt = dcw_pkg::PS_FAULT;
      endcase
      if (faultActive) begin
         ps_nxt = dcw_pkg::PS_FAULT;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ps_r <= dcw_pkg::PS_ON_DISABLED;
      end else if (clkEn) begin
         ps_r <= ps_nxt;
      end
   end

   // -------------------------------------------------------------
   // motion order, jog and homing
   // -------------------------------------------------------------
   logic        active_r, active_nxt;
   logic        ack_r, ack_nxt;
   logic        refValid_r, refValid_nxt;
   logic        home_r, home_nxt;
   logic        start_r, start_nxt;
   logic        disc_r, disc_nxt;
   logic        posRst_r, posRst_nxt;
   logic        jogP_r, jogP_nxt, jogN_r, jogN_nxt;
   logic        run_r, run_nxt;
   logic        pwr_r, pwr_nxt;
   logic [2:0]  ramp_r, ramp_nxt;
   logic        enabled;

   assign enabled = (ps_r == dcw_pkg::PS_OP_ENABLED) && enOp;

   always_comb begin
      active_nxt   = active_r;
      ack_nxt      = ack_r;
      refValid_nxt = refValid_r | (home_r & homingDone);
      home_nxt     = home_r & ~homingDone;
      start_nxt    = 1'b0;
      disc_nxt     = 1'b0;
      posRst_nxt   = 1'b0;
      if (active_r && (!permit || !enabled)) begin
         active_nxt = 1'b0;
         disc_nxt   = 1'b1;
      end else if (active_r && targetReached && noPause) begin
         active_nxt = 1'b0;
      end
      // accept after completion, so a new order is never lost to it
      if (enabled && permit && toggleEdge) begin
         active_nxt = 1'b1;
         start_nxt  = 1'b1;
         ack_nxt    = cw_r[dcw_pkg::CW_TOGGLE];
         posRst_nxt = cw_r[dcw_pkg::CW_CONTINUOUS];
      end
      // homing start on rising edge, abort on clear
      if (enabled && homeRise) begin
         home_nxt     = 1'b1;
         refValid_nxt = 1'b0;
      end else if (!cw_r[dcw_pkg::CW_HOME] || !enabled) begin
         home_nxt = 1'b0;
      end
      // jog needs zero commanded speed: no order and no homing
      jogP_nxt = enabled && cw_r[dcw_pkg::CW_JOG_POS]
                 && !active_r && !home_r;
      jogN_nxt = enabled && cw_r[dcw_pkg::CW_JOG_NEG]
                 && !cw_r[dcw_pkg::CW_JOG_POS]
                 && !active_r && !home_r;
      // pause holds the order, except velocity and gearing keep moving
      run_nxt = active_nxt && (noPause || velocityOrGearing);
      pwr_nxt = (ps_nxt != dcw_pkg::PS_ON_DISABLED)
                && (ps_nxt != dcw_pkg::PS_READY_ON)
                && (ps_nxt != dcw_pkg::PS_FAULT);
      // ramp priority: quick, off, disable, permit, pause, homing abort, jog
      priority case (1'b1)
         ps_nxt == dcw_pkg::PS_QUICK_STOP: ramp_nxt = dcw_pkg::RAMP_QUICK;
         ps_nxt == dcw_pkg::PS_RAMP_OFF:   ramp_nxt = dcw_pkg::RAMP_FIRST;
         ps_nxt == dcw_pkg::PS_OP_ENABLED && !enOp:
            ramp_nxt = dcw_pkg::RAMP_STOP;
         disc_nxt:                         ramp_nxt = dcw_pkg::RAMP_MAX;
         active_nxt && !run_nxt:           ramp_nxt = dcw_pkg::RAMP_STOP;
         home_r && !home_nxt && !homingDone:
            ramp_nxt = dcw_pkg::RAMP_STOP;
         (jogP_r && !jogP_nxt) || (jogN_r && !jogN_nxt):
            ramp_nxt = dcw_pkg::RAMP_JOG;
         default:                          ramp_nxt = dcw_pkg::RAMP_NONE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_r   <= 1'b0;
         ack_r      <= 1'b0;
         refValid_r <= 1'b0;
         home_r     <= 1'b0;
         start_r    <= 1'b0;
         disc_r     <= 1'b0;
         posRst_r   <= 1'b0;
         jogP_r     <= 1'b0;
         jogN_r     <= 1'b0;
         run_r      <= 1'b0;
         pwr_r      <= 1'b0;
         ramp_r     <= dcw_pkg::RAMP_NONE;
      end else if (clkEn) begin
         active_r   <= active_nxt;
         ack_r      <= ack_nxt;
         refValid_r <= refValid_nxt;
         home_r     <= home_nxt;
         start_r    <= start_nxt;
         disc_r     <= disc_nxt;
         posRst_r   <= posRst_nxt;
         jogP_r     <= jogP_nxt;
         jogN_r     <= jogN_nxt;
         run_r      <= run_nxt;
         pwr_r      <= pwr_nxt;
         ramp_r     <= ramp_nxt;
      end
   end

   // -------------------------------------------------------------
   // status word, registered
   // -------------------------------------------------------------
   logic [15:0] sw_r, sw_nxt;

   always_comb begin
      sw_nxt = 16'h0000;
      sw_nxt[dcw_pkg::SW_READY_ON]   = ps_r == dcw_pkg::PS_READY_ON
                                       || pwr_r;
      sw_nxt[dcw_pkg::SW_READY_OP]   = ps_r == dcw_pkg::PS_READY_OP
                                       || ps_r == dcw_pkg::PS_OP_ENABLED;
      sw_nxt[dcw_pkg::SW_OP_ENABLED] = ps_r == dcw_pkg::PS_OP_ENABLED;
      sw_nxt[dcw_pkg::SW_FAULT]      = ps_r == dcw_pkg::PS_FAULT;
      sw_nxt[dcw_pkg::SW_NO_COAST]   = noCoast;
      sw_nxt[dcw_pkg::SW_NO_QSTOP]   = noQstop;
      sw_nxt[dcw_pkg::SW_ON_DISABLE] = ps_r == dcw_pkg::PS_ON_DISABLED;
      sw_nxt[dcw_pkg::SW_GUIDANCE]   = cw_r[dcw_pkg::CW_GUIDANCE];
      sw_nxt[dcw_pkg::SW_TARGET]     = targetReached;
      sw_nxt[dcw_pkg::SW_REF_VALID]  = refValid_r;
      sw_nxt[dcw_pkg::SW_SET_ACK]    = ack_r;
      sw_nxt[dcw_pkg::SW_STOPPED]    = axisStopped;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sw_r <= 16'h0000;
      end else if (clkEn) begin
         sw_r <= sw_nxt;
      end
   end

   // outputs straight from flip-flops
   assign driveStatusWord = sw_r;
   assign powerStageOn    = pwr_r;
   assign rampSelect      = ramp_r;
   assign motionRun       = run_r;
   assign orderStart      = start_r;
   assign orderDiscard    = disc_r;
   assign positionReset   = posRst_r;
   assign jogPos          = jogP_r;
   assign jogNeg          = jogN_r;
   assign homingRun       = home_r;
   // localInputWord is deliberately left unmerged (no local guidance)
   logic unusedLocal;
   assign unusedLocal = ^localInputWord;
endmodule

// File: bench/dcw_decoder_monitor.sv
/*
 * port checker for the drive control word decoder.
 * assumes it is bound onto dcw_decoder and sees only its ports.
 */
`timescale 1ns/1ps
module dcw_decoder_monitor (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [15:0] motionControlWord,
   input wire logic [15:0] driveStatusWord,
   input wire logic        powerStageOn,
   input wire logic [2:0]  rampSelect,
   input wire logic        orderStart,
   input wire logic        orderDiscard,
   input wire logic        positionReset,
   input wire logic        jogPos,
   input wire logic        jogNeg,
   input wire logic        homingRun
);
   // -------------------------------------------------------------
   // relations between the decoder outputs
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ack shows in the status word one cycle after the start pulse
   ack_level_a: assert property (orderStart |=>
      driveStatusWord[dcw_pkg::SW_SET_ACK] == motionControlWord[6])
      else $error("set ack differs from toggle bit");
   start_pulse_a: assert property (orderStart |=> !orderStart)
      else $error("order start longer than one cycle");
   start_enabled_a: assert property (orderStart |->
      driveStatusWord[dcw_pkg::SW_OP_ENABLED])
      else $error("order started while not enabled");
   reset_pair_a: assert property (positionReset |-> orderStart)
      else $error("position reset without order start");
   // four cycles covers the capture and output latency
   guide_hold_a: assert property ((!motionControlWord[10]) [*4]
      |-> !orderStart)
      else $error("order started without guidance");
   discard_brake_a: assert property (orderDiscard |->
      ##[0:3] rampSelect == dcw_pkg::RAMP_MAX)
      else $error("discard without maximum brake");
   jog_enabled_a: assert property ((jogPos || jogNeg) |->
      driveStatusWord[dcw_pkg::SW_OP_ENABLED])
      else $error("jog while not enabled");
   jog_single_a: assert property (jogPos |-> !jogNeg)
      else $error("both jog directions active");
   coast_off_a: assert property (
      driveStatusWord[dcw_pkg::SW_ON_DISABLE] |-> !powerStageOn)
      else $error("power stage on while disabled");
   homing_ref_a: assert property (homingRun |=>
      !driveStatusWord[dcw_pkg::SW_REF_VALID])
      else $error("reference valid during homing");
endmodule

// File: bench/dcw_master_model.sv
/*
 * fieldbus master model: forms the control word from a bench command.
 * assumes the bench gives commands on the falling clock edge.
 */
`timescale 1ns/1ps
module dcw_master_model (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [15:0] cmdWord,
   input wire logic        toggleReq,
   input wire logic [15:0] statusWord,
   output logic     [15:0] motionControlWord
);
   // -------------------------------------------------------------
   // toggle level, moved only after the previous order is acked
   // -------------------------------------------------------------
   logic toggleLvl_r;
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         toggleLvl_r <= 1'b0;
      else if (toggleReq && statusWord[12] == toggleLvl_r)
         toggleLvl_r <= ~toggleLvl_r;
   end
   // reserved and factory bits always sent as zero
   assign motionControlWord = {1'b0, cmdWord[14], 2'b00,
                               cmdWord[11:7], toggleLvl_r, cmdWord[5:0]};
endmodule

// File: bench/dcw_decoder_test.sv
/*
 * self-checking bench for the drive control word decoder.
 * assumes the master model and the bound port checker.
 */
`timescale 1ns/1ps
module dcw_decoder_test;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] cmdWord = 16'h0000;
   logic        toggleReq = 1'b0;
   logic [15:0] localInputWord = 16'h0000;
   logic        faultActive = 1'b0;
   logic        faultRemoved = 1'b0;
   logic        axisStopped = 1'b1;
   logic        homingDone = 1'b0;
   logic        velocityOrGearing = 1'b0;
   logic [15:0] motionControlWord, driveStatusWord;
   logic [2:0]  rampSelect;
   logic        powerStageOn, motionRun, orderStart, orderDiscard;
   logic        positionReset, jogPos, jogNeg, homingRun;
   logic [31:0] seed = 32'h00018123;
   int          failures = 0;
   int          total_checks = 0;
   int          ps = 0;
   logic        lvl = 1'b0;
   logic [15:0] up[3] = '{16'h0406, 16'h0407, 16'h040F};
   logic [15:0] stw[3] = '{16'h0437, 16'h0436, 16'h043B};
   logic [2:0]  str[3] = '{dcw_pkg::RAMP_STOP, dcw_pkg::RAMP_FIRST,
                           dcw_pkg::RAMP_QUICK};
   logic [15:0] jw[3] = '{16'h053F, 16'h063F, 16'h073F};

   // -------------------------------------------------------------
   // clock, random local inputs, instances
   // -------------------------------------------------------------
   always #25 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // local inputs churn so any merging would upset the results
   always @(negedge core_clk) begin
      seed <= lfsr(seed);
      localInputWord <= seed[15:0];
   end
   dcw_decoder i_dut (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
      .motionControlWord(motionControlWord),
      .localInputWord(localInputWord), .faultActive(faultActive),
      .faultRemoved(faultRemoved), .axisStopped(axisStopped),
      .homingDone(homingDone), .targetReached(1'b0),
      .velocityOrGearing(velocityOrGearing),
      .driveStatusWord(driveStatusWord), .powerStageOn(powerStageOn),
      .rampSelect(rampSelect), .motionRun(motionRun),
      .orderStart(orderStart), .orderDiscard(orderDiscard),
      .positionReset(positionReset), .jogPos(jogPos), .jogNeg(jogNeg),
      .homingRun(homingRun));
   dcw_master_model i_master (.core_clk(core_clk), .rst(rst),
      .cmdWord(cmdWord), .toggleReq(toggleReq),
      .statusWord(driveStatusWord), .motionControlWord(motionControlWord));

   // -------------------------------------------------------------
   // power state model and helpers
   // -------------------------------------------------------------
   // 0 disabled, 1 ready on, 2 ready op, 3 enabled, 4 after quick stop
   function automatic int nxt(int p, logic [15:0] w);
      if (!w[10]) return p;
      if (!w[1]) return 0;
      if (!w[2]) return (p == 0) ? 0 : 4;
      if (p == 0) return w[0] ? 0 : 1;
      if (p == 1 || p == 4) return w[0] ? 2 : 1;
      return !w[0] ? 1 : (w[3] ? 3 : 2);
   endfunction
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic put(logic [15:0] w);
      @(negedge core_clk);
      cmdWord = w;
      repeat (4) @(negedge core_clk);
      repeat (3) ps = nxt(ps, w);
   endtask
   task automatic chkps();
      chk("opEnabled", ps == 3, driveStatusWord[dcw_pkg::SW_OP_ENABLED]);
      chk("powerStageOn", ps == 2 || ps == 3, powerStageOn);
      if (ps != 4)
         chk("onDisabled", ps == 0, driveStatusWord[dcw_pkg::SW_ON_DISABLE]);
      if (ps < 2)
         chk("readyOn", ps == 1, driveStatusWord[dcw_pkg::SW_READY_ON]);
   endtask
   // bounded wait for a one-cycle pulse, a miss ends the run
   task automatic waitSig(bit k);
      int i;
      for (i = 0; i < 8; i++) begin
         @(negedge core_clk);
         if ((k ? orderDiscard : orderStart) === 1'b1) break;
      end
      chk(k ? "orderDiscard" : "orderStart", 1, i < 8);
      if (i == 8) final_report();
   endtask
   task automatic tgl();
      @(negedge core_clk);
      toggleReq = 1'b1;
      @(negedge core_clk);
      toggleReq = 1'b0;
      lvl = ~lvl;
      waitSig(0);
      chk("positionReset", 1, positionReset);
      // the status word follows the start pulse by one cycle
      @(negedge core_clk);
      chk("setAck", lvl, driveStatusWord[dcw_pkg::SW_SET_ACK]);
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (20) @(negedge core_clk);
      chk("resetPower", 0, powerStageOn);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      chkps();
      $display("test reset done");
      foreach (up[i]) begin
         put(up[i]);
         chkps();
      end
      $display("test power up done");
      put(16'h443F);
      repeat (2) tgl();
      put(16'h441F);
      chk("motionPaused", 0, motionRun);
      velocityOrGearing = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("motionGearing", 1, motionRun);
      velocityOrGearing = 1'b0;
      put(16'h443F);
      chk("motionResumed", 1, motionRun);
      @(negedge core_clk);
      cmdWord = 16'h442F;
      waitSig(1);
      $display("test orders done");
      put(16'h000E);
      chkps();
      put(16'h043F);
      foreach (jw[i]) begin
         put(jw[i]);
         chk("jogPos", i != 1, jogPos);
         chk("jogNeg", i == 1, jogNeg);
         put(16'h043F);
         chk("jogOff", 0, jogPos | jogNeg);
         chkps();
      end
      put(16'h0C3F);
      chk("homingRun", 1, homingRun);
      // finish one homing run so a later start has a reference to clear
      homingDone = 1'b1;
      @(negedge core_clk);
      homingDone = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("refSet", 1, driveStatusWord[dcw_pkg::SW_REF_VALID]);
      put(16'h043F);
      put(16'h0C3F);
      chk("homingRun", 1, homingRun);
      chk("refValid", 0, driveStatusWord[dcw_pkg::SW_REF_VALID]);
      put(16'h043F);
      chk("homingAbort", 0, homingRun);
      $display("test jog and homing done");
      foreach (stw[i]) begin
         put(16'h043F);
         axisStopped = 1'b0;
         put(stw[i]);
         chk("rampSelect", str[i], rampSelect);
         axisStopped = 1'b1;
         repeat (4) @(negedge core_clk);
         chkps();
      end
      put(16'h0439);
      chkps();
      $display("test stops done");
      faultActive = 1'b1;
      put(16'h0404);
      faultActive = 1'b0;
      faultRemoved = 1'b1;
      put(16'h0404);
      chk("faultHeld", 1, driveStatusWord[dcw_pkg::SW_FAULT]);
      put(16'h0484);
      chk("faultClear", 0, driveStatusWord[dcw_pkg::SW_FAULT]);
      chkps();
      $display("test fault done");
      final_report();
   end
endmodule

bind dcw_decoder dcw_decoder_monitor i_mon (.core_clk(core_clk),
   .rst(rst), .motionControlWord(motionControlWord),
   .driveStatusWord(driveStatusWord), .powerStageOn(powerStageOn),
   .rampSelect(rampSelect), .orderStart(orderStart),
   .orderDiscard(orderDiscard), .positionReset(positionReset),
   .jogPos(jogPos), .jogNeg(jogNeg), .homingRun(homingRun));
